// ===== design/lvds_serdes_lane.v
// LVDS lane: deserializer, serializer, receive queue, delay and phase align, AXI4-Lite slave
`include "lvds_serdes_lane_defines.vh"

// Overview of operation
// [RULE_01] Receive word up to ten bits, width set
// [RULE_02] Received word updates on each parallel tick
// [RULE_03] Alternate input only in bypass, width one
// [RULE_04] Lock output once phase alignment trains
// [RULE_05] Queue empty flag while queue holds nothing
// [RULE_06] Core pops queue only when not empty
// [RULE_07] Receive reset clears queue and deserializer
// [RULE_08] Input buffer enable switches receiver on/off
// [RULE_09] Termination control connects or disconnects termination
// [RULE_10] Delay enable drives delay or phase align
// [RULE_11] Step direction up or down, unused with align
// [RULE_12] Delay reset clears counter or align circuit
// [RULE_13] Transmit word captured on parallel tick
// [RULE_14] Transmit serial data or clock pattern
// [RULE_15] Transmit reset clears the serializer
// [RULE_16] Pad driven only while output enable high
// [RULE_17] Both paths use same serialization factor
// [RULE_18] Separate receive and transmit timing and resets
// [RULE_19] Debug output shows final tap at lock
// [RULE_20] Full rate one edge, half rate both
// [RULE_21] Parallel rate is bit rate over factor
// [RULE_22] Eight-entry receive queue, receive path only
// [RULE_23] Phase alignment only in full-rate mode
// [RULE_24] Lock cleared on align reset until retrained
module lvds_serdes_lane (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire        ce,
   input  wire [4:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [4:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire        pad_in,
   output reg         pad_p,
   output reg         pad_n,
   output reg         pad_oe,
   output reg         input_buffer_on,
   output reg         termination_on,
   output reg         serial_clk,
   output reg         rx_parallel_clk,
   output reg         tx_parallel_clk,
   output reg         alternate_pad_input,
   output reg         lock,
   output reg         fifo_empty,
   output reg  [5:0]  align_final_tap,
   output reg  [9:0]  rx_word
);
   reg [31:0] ctrl_q;
   reg [4:0]  aw_q;
   reg [31:0] w_q;
   reg [3:0]  ws_q;
   reg        aw_have_q;
   reg        w_have_q;
   reg        sync1_q;
   reg        sync2_q;
   reg        phase_q;
   reg [9:0]  rx_shift_q;
   reg [3:0]  rx_idx_q;
   reg [9:0]  tx_shift_q;
   reg [3:0]  tx_idx_q;
   reg [9:0]  tx_word_q;
   reg        dly_en_q;
   reg        dly_up_q;
   reg        delay_reset_q;
   reg [5:0]  tap_q;
   reg [9:0]  prev_word_q;
   reg [2:0]  stable_q;
   reg [9:0]  mem [0:7];
   reg [2:0]  wr_q;
   reg [2:0]  rd_q;
   reg [3:0]  cnt_q;

   wire [3:0] width = (ctrl_q[15:12] == 4'h0) ? 4'h1 :
                      (ctrl_q[15:12] > 4'hA) ? 4'hA : ctrl_q[15:12];
   wire       fifo_on = ctrl_q[`CTRL_FIFO_EN];
   // Alignment only trains at full rate
   wire       dpa_on = ctrl_q[`CTRL_DPA_EN] & ~ctrl_q[`CTRL_HALF_RATE]; // see [RULE_23]
   wire       bit_tick = ce & phase_q;
   // A width cut mid-word ends the word at once, so no index leaves the word
   wire       rx_last = bit_tick & (rx_idx_q >= width - 4'h1);
   wire       tx_last = bit_tick & (tx_idx_q >= width - 4'h1);
   wire       wr_do = aw_have_q & w_have_q & ~s_axi_bvalid;
   wire       rx_rst = wr_do & (aw_q == `REG_RESET) & ws_q[0] & w_q[`RST_RX];
   wire       tx_rst = wr_do & (aw_q == `REG_RESET) & ws_q[0] & w_q[`RST_TX];
   wire       rd_take = s_axi_arvalid & ~s_axi_rvalid;
   wire       pop = ce & rd_take & (s_axi_araddr == `REG_RXDATA) & fifo_on & ~fifo_empty;
   wire [9:0] new_word = rx_shift_q | ({9'h0, sync2_q} << rx_idx_q);
   wire       rx_run = ctrl_q[`CTRL_RX] & input_buffer_on;
   wire       push = rx_last & rx_run & fifo_on & (~dpa_on | lock) & (cnt_q != 4'h8);
   wire [31:0] tx_merged = merge({22'h0, tx_word_q}, w_q, ws_q);

   function [9:0] mask_w;
      input [3:0] w;
      begin
         mask_w = ~(10'h3FF << w);
      end
   endfunction

   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0]  st;
      integer      i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1) begin
            if (st[i]) begin
               merge[i*8 +: 8] = nw[i*8 +: 8];
            end
         end
      end
   endfunction

   function mapped;
      input [4:0] a;
      begin
         mapped = (a == `REG_CTRL) | (a == `REG_DELAY) | (a == `REG_TXDATA) |
                  (a == `REG_RXDATA) | (a == `REG_STATUS) | (a == `REG_RESET);
      end
   endfunction

   // Bus write side: address and data taken in either order
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
         aw_q <= 5'h00;
         w_q <= 32'h0000_0000;
         ws_q <= 4'h0;
         ctrl_q <= `CTRL_RESET;
         tx_word_q <= 10'h000;
      end else if (ce) begin
         s_axi_awready <= ~aw_have_q & ~s_axi_awready & s_axi_awvalid;
         s_axi_wready <= ~w_have_q & ~s_axi_wready & s_axi_wvalid;
         if (s_axi_awready & s_axi_awvalid) begin
            aw_have_q <= 1'b1;
            aw_q <= {s_axi_awaddr[4:2], 2'b00};
         end
         if (s_axi_wready & s_axi_wvalid) begin
            w_have_q <= 1'b1;
            w_q <= s_axi_wdata;
            ws_q <= s_axi_wstrb;
         end
         if (wr_do) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped(aw_q) ? `RESP_OKAY : `RESP_SLVERR;
            if (aw_q == `REG_CTRL) begin
               ctrl_q <= merge(ctrl_q, w_q, ws_q);
            end
            if (aw_q == `REG_TXDATA) begin
               tx_word_q <= tx_merged[9:0];
            end
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Bus read side; reading the data register pops the queue
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `RESP_OKAY;
      end else if (ce) begin
         s_axi_arready <= rd_take;
         if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
            case (s_axi_araddr)
               `REG_CTRL: begin
                  s_axi_rdata <= ctrl_q;
               end
               `REG_RXDATA: begin
                  s_axi_rdata <= {22'h0, (fifo_on ? mem[rd_q] : rx_word)};
               end
               `REG_STATUS: begin
                  s_axi_rdata <= {10'h0, tap_q, align_final_tap, 4'h0,
                                  cnt_q, fifo_empty, lock};
               end
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
               end
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Pad input passes two flops; each bit lasts two cycles
   always @(posedge aclk) begin
      if (!aresetn) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         phase_q <= 1'b0;
         serial_clk <= 1'b0;
         input_buffer_on <= 1'b0;
         termination_on <= 1'b0;
         alternate_pad_input <= 1'b0;
      end else if (ce) begin
         sync1_q <= pad_in;
         sync2_q <= sync1_q;
         phase_q <= ~phase_q;
         // Full rate toggles each cycle, half rate once per bit
         serial_clk <= ctrl_q[`CTRL_HALF_RATE] ? (serial_clk ^ phase_q) : ~serial_clk; // see [RULE_20]
         input_buffer_on <= ctrl_q[`CTRL_BUF_ON]; // see [RULE_08]
         termination_on <= ctrl_q[`CTRL_TERM_ON]; // see [RULE_09]
         alternate_pad_input <= ctrl_q[`CTRL_BYPASS] & (width == 4'h1) &
                                ctrl_q[`CTRL_RX] & input_buffer_on & sync2_q; // see [RULE_03]
      end
   end

   // Deserializer, first bit in bit 0
   always @(posedge aclk) begin
      if (!aresetn || (ce && rx_rst)) begin // see [RULE_07]
         rx_shift_q <= 10'h000;
         rx_idx_q <= 4'h0;
         rx_word <= 10'h000;
         rx_parallel_clk <= 1'b0;
      end else if (bit_tick && ctrl_q[`CTRL_RX] && input_buffer_on) begin
         if (rx_last) begin
            rx_idx_q <= 4'h0;
            rx_shift_q <= 10'h000;
            rx_parallel_clk <= 1'b1; // see [RULE_21]
            rx_word <= new_word & mask_w(width); // see [RULE_01] [RULE_02]
         end else begin
            rx_idx_q <= rx_idx_q + 4'h1;
            rx_shift_q <= new_word;
            rx_parallel_clk <= (rx_idx_q < {1'b0, width[3:1]}) ? 1'b1 : 1'b0;
         end
      end
   end

   // Delay controls are held until the next word boundary
   always @(posedge aclk) begin
      if (!aresetn) begin
         dly_en_q <= 1'b0;
         dly_up_q <= 1'b0;
         delay_reset_q <= 1'b0;
      end else if (ce) begin
         if (wr_do && aw_q == `REG_DELAY && ws_q[0]) begin
            dly_en_q <= w_q[`DLY_ENABLE];
            dly_up_q <= w_q[`DLY_UP];
            delay_reset_q <= w_q[`DLY_RESET];
         end else if (rx_last) begin
            dly_en_q <= 1'b0;
            delay_reset_q <= 1'b0;
         end
      end
   end

   // Delay chain and phase alignment training
   always @(posedge aclk) begin
      if (!aresetn || (ce && rx_rst)) begin
         tap_q <= 6'h00;
         lock <= 1'b0;
         stable_q <= 3'h0;
         prev_word_q <= 10'h000;
         align_final_tap <= 6'h00;
      end else if (rx_last) begin
         prev_word_q <= new_word & mask_w(width);
         if (delay_reset_q) begin
            tap_q <= 6'h00; // see [RULE_12]
            stable_q <= 3'h0;
            if (dpa_on) begin
               lock <= 1'b0; // see [RULE_24]
            end
         end else if (!dpa_on) begin
            lock <= 1'b0;
            if (dly_en_q) begin
               // Step direction is ignored while aligning
               tap_q <= dly_up_q ? tap_q + 6'h01 : tap_q - 6'h01; // see [RULE_10] [RULE_11]
            end
         end else if (dly_en_q && !lock) begin
            // Training: sweep taps until the word stays stable
            if ((new_word & mask_w(width)) == prev_word_q) begin
               stable_q <= stable_q + 3'h1;
               if (stable_q == `ALIGN_STABLE - 3'h1) begin
                  lock <= 1'b1; // see [RULE_04]
                  align_final_tap <= tap_q; // see [RULE_19]
               end
            end else begin
               stable_q <= 3'h0;
               tap_q <= tap_q + 6'h01;
            end
         end
      end
   end

   // Eight-word receive queue
   always @(posedge aclk) begin
      if (!aresetn || (ce && rx_rst)) begin // see [RULE_07]
         wr_q <= 3'h0;
         rd_q <= 3'h0;
         cnt_q <= 4'h0;
         fifo_empty <= 1'b1;
      end else if (ce) begin
         if (push) begin
            mem[wr_q] <= new_word & mask_w(width); // see [RULE_22]
            wr_q <= wr_q + 3'h1;
         end
         // Pop is gated by empty, so a stray read returns stale data only
         if (pop) begin // see [RULE_06]
            rd_q <= rd_q + 3'h1;
         end
         cnt_q <= cnt_q + {3'h0, push} - {3'h0, pop};
         fifo_empty <= (cnt_q + {3'h0, push} - {3'h0, pop}) == 4'h0; // see [RULE_05]
      end
   end

   // Serializer with its own reset and word counter
   always @(posedge aclk) begin
      if (!aresetn || (ce && tx_rst)) begin // see [RULE_15] [RULE_18]
         tx_shift_q <= 10'h000;
         tx_idx_q <= 4'h0;
         tx_parallel_clk <= 1'b0;
         pad_p <= 1'b0;
         pad_n <= 1'b1;
         pad_oe <= 1'b0;
      end else if (ce) begin
         pad_oe <= ctrl_q[`CTRL_TX] & ctrl_q[`CTRL_OE]; // see [RULE_16]
         if (bit_tick && ctrl_q[`CTRL_TX]) begin
            pad_p <= tx_shift_q[tx_idx_q];
            pad_n <= ~tx_shift_q[tx_idx_q];
            if (tx_last) begin
               tx_idx_q <= 4'h0;
               tx_parallel_clk <= 1'b1;
               // Clock pattern: low half of the word high, upper half low
               tx_shift_q <= ctrl_q[`CTRL_CLK_PAT] ? mask_w({1'b0, width[3:1]}) :
                             tx_word_q & mask_w(width); // see [RULE_13] [RULE_14] [RULE_17]
            end else begin
               tx_idx_q <= tx_idx_q + 4'h1;
               tx_parallel_clk <= (tx_idx_q < {1'b0, width[3:1]}) ? 1'b1 : 1'b0;
            end
         end
      end
   end
endmodule

// ===== design/lvds_serdes_lane_defines.vh
// Register map, field positions, reset values and counts of the LVDS lane
`ifndef LVDS_SERDES_LANE_DEFINES_VH
`define LVDS_SERDES_LANE_DEFINES_VH
`define REG_CTRL        5'h00
`define REG_DELAY       5'h04
`define REG_TXDATA      5'h08
`define REG_RXDATA      5'h0C
`define REG_STATUS      5'h10
`define REG_RESET       5'h14
`define CTRL_RESET      32'h0000_8000
`define CTRL_RX         0
`define CTRL_TX         1
`define CTRL_BUF_ON     2
`define CTRL_TERM_ON    3
`define CTRL_OE         4
`define CTRL_FIFO_EN    5
`define CTRL_DPA_EN     6
`define CTRL_HALF_RATE  7
`define CTRL_CLK_PAT    8
`define CTRL_BYPASS     9
`define CTRL_WIDTH_LSB  12
`define DLY_ENABLE      0
`define DLY_UP          1
`define DLY_RESET       2
`define RST_RX          0
`define RST_TX          1
`define WORD_W          10
`define TAP_W           6
`define FIFO_DEPTH      8
`define ALIGN_STABLE    3'h4
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`endif

// ===== sim/lane_port_checks_properties.sv
// Concurrent checks on the LVDS lane ports
`include "lvds_serdes_lane_defines.vh"
module lane_port_checks (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        pad_p,
   input wire logic        pad_n,
   input wire logic        lock,
   input wire logic        fifo_empty,
   input wire logic [5:0]  align_final_tap
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   pad_pair_a: assert property (pad_n != pad_p)
      else $error("Pad pair not complementary");
   reset_state_a: assert property ($rose(aresetn) |-> fifo_empty && !lock)
      else $error("Lane not idle after reset");
   write_resp_a: assert property (s_axi_awready && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("Write answer late");
   b_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("Write answer not withdrawn");
   r_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("Read answer not withdrawn");
   ar_pair_a: assert property ($rose(s_axi_arready) |-> $rose(s_axi_rvalid))
      else $error("Read accept and answer apart");
   aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
      else $error("Address accept held too long");
   err_zero_a: assert property (s_axi_rvalid && s_axi_rresp == `RESP_SLVERR |-> s_axi_rdata == 0)
      else $error("Refused read carries data");
   tap_hold_a: assert property (lock ##1 lock |-> $stable(align_final_tap))
      else $error("Final tap moved while locked");
   cover property ($rose(lock));
   cover property ($fell(fifo_empty));
   cover property (s_axi_rvalid && s_axi_rresp == `RESP_SLVERR);
endmodule

bind lvds_serdes_lane lane_port_checks chk (
   .aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
   .pad_p, .pad_n, .lock, .fifo_empty, .align_final_tap);

// ===== sim/lane_far_end.sv
// Far-end model: loops the lane's pad output back to its input
module lane_far_end (
   input  wire logic aclk,
   input  wire logic pad_p,
   input  wire logic pad_oe,
   output logic      pad_in
);
   timeunit 1ns;
   timeprecision 1ns;
   logic idle_q = 1'b0;
   // A released wire toggles each cycle, which the deserializer samples once per bit as one steady level
   always @(posedge aclk)
      idle_q <= !idle_q;
   // One wire for both paths keeps both at one serialization factor
   assign pad_in = pad_oe ? pad_p : idle_q;
endmodule

// ===== sim/tb_lvds_serdes_lane.sv
// Self-checking bench for the LVDS lane with a loopback far end
`include "lvds_serdes_lane_defines.vh"
module tb_lvds_serdes_lane;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [9:0] LOOP = 10'h017;
   localparam logic [9:0] FIFO = 10'h020;
   localparam logic [1:0] OK = `RESP_OKAY;
   logic        aclk, aresetn, ce, pad_in, pad_p, pad_n, pad_oe, input_buffer_on, p;
   logic        termination_on, serial_clk, alternate_pad_input, lock, fifo_empty;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [4:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [5:0]  align_final_tap;
   logic [9:0]  rx_word;
   logic [33:0] exp_q[$];
   logic [33:0] e;
   logic [2:0]  dly[5] = '{3'h3, 3'h3, 3'h2, 3'h1, 3'h4};
   logic [5:0]  tap[5] = '{6'h01, 6'h02, 6'h02, 6'h01, 6'h00};
   int          errors, check_count, n, ew;
   int unsigned seed;

   lvds_serdes_lane dut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pad_in, .pad_p, .pad_n, .pad_oe,
      .input_buffer_on, .termination_on, .serial_clk, .rx_parallel_clk(),
      .tx_parallel_clk(), .alternate_pad_input, .lock, .fifo_empty, .align_final_tap,
      .rx_word);
   lane_far_end far (.aclk, .pad_p, .pad_oe, .pad_in);

   always #50 aclk = ~aclk;

   task automatic check(input string nm, input logic [33:0] s, input logic [33:0] x);
      check_count++;
      if (s !== x) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, x, s);
      end
   endtask

   task automatic finish_test;
      $display("Counts: %0d checks, %0d mismatches", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
      logic aw_ok, w_ok;
      exp_q.push_back({r, 32'h0000_0000});
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         aw_ok |= s_axi_awready;
         w_ok |= s_axi_wready;
         s_axi_awvalid <= !aw_ok;
         s_axi_wvalid <= !w_ok;
      end
      while (!s_axi_bvalid)
         @(posedge aclk);
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
      exp_q.push_back({r, d});
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
         @(posedge aclk);
      while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      while (!s_axi_rvalid)
         @(posedge aclk);
      s_axi_rready <= 1'b0;
   endtask

   function automatic logic [31:0] cw(input logic [9:0] m, input logic [3:0] w);
      return {16'h0000, w, 2'h0, m};
   endfunction

   // Alignment only counts words while an enable is pending, so keep asking
   task automatic train(input logic [9:0] m);
      wr(`REG_CTRL, cw(m, 4'h4), OK);
      repeat (8) begin
         wr(`REG_DELAY, 32'h0000_0001, OK);
         repeat (10) @(posedge aclk);
      end
   endtask

   // Answers are compared in the order the requests were made
   always @(posedge aclk)
      if (s_axi_bvalid && s_axi_bready || s_axi_rvalid && s_axi_rready) begin
         e = exp_q.pop_front();
         check("bus answer", s_axi_bvalid ? {s_axi_bresp, 32'h0} : {s_axi_rresp, s_axi_rdata}, e);
      end

   initial begin
      #2_000_000;
      errors++;
      finish_test();
   end

   initial begin
      {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
      {s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      ce = 1'b1;
      s_axi_wstrb = 4'hF;
      seed = $urandom(52);
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`REG_CTRL, `CTRL_RESET, OK);
      rd(`REG_STATUS, 32'h0000_0002, OK);
      rd(5'h18, 32'h0000_0000, `RESP_SLVERR);
      wr(5'h1C, 32'hFFFF_FFFF, `RESP_SLVERR);
      $display("Test reset and map done");
      for (int w = 0; w < 12; w++) begin
         ew = w == 0 ? 1 : w > 10 ? 10 : w;
         wr(`REG_CTRL, cw(LOOP | 10'(w % 2) << `CTRL_HALF_RATE, 4'(w)), OK);
         wr(`REG_TXDATA, $urandom << ew, OK);
         repeat (100) @(posedge aclk);
         check("rx_word zero", rx_word, 0);
         n = 0;
         p = serial_clk;
         repeat (8) begin
            @(posedge aclk);
            n += serial_clk !== p;
            p = serial_clk;
         end
         check("serial_clk toggles", n, w % 2 ? 4 : 8);
         wr(`REG_TXDATA, $urandom << ew | (32'h1 << ew) - 1, OK);
         repeat (100) @(posedge aclk);
         check("rx_word ones", rx_word, (34'h1 << ew) - 1);
      end
      $display("Test widths done");
      wr(`REG_CTRL, cw(LOOP, 4'h4), OK);
      repeat (100) @(posedge aclk);
      for (int k = 0; k < 2; k++) begin
         wr(`REG_CTRL, cw(LOOP | FIFO, 4'h4), OK);
         repeat (100) @(posedge aclk);
         wr(`REG_CTRL, cw(LOOP & 10'h3FE | FIFO, 4'h4), OK);
         rd(`REG_STATUS, 32'h0000_0020, OK);
         check("fifo_empty", fifo_empty, 0);
         if (k == 0)
            repeat (9) rd(`REG_RXDATA, 32'h0000_000F, OK);
         else
            wr(`REG_RESET, 32'h0000_0001, OK);
         rd(`REG_STATUS, 32'h0000_0002, OK);
         check("fifo_empty", fifo_empty, 1);
      end
      wr(`REG_RESET, 32'h0000_0000, OK);
      $display("Test receive queue done");
      wr(`REG_CTRL, cw(LOOP, 4'h4), OK);
      foreach (dly[i]) begin
         wr(`REG_DELAY, {29'h0, dly[i]}, OK);
         repeat (30) @(posedge aclk);
         rd(`REG_STATUS, {10'h0, tap[i], 14'h0, 2'h2}, OK);
      end
      $display("Test delay steps done");
      train(LOOP | 10'h040);
      check("lock", lock, 1);
      check("final tap", align_final_tap, 0);
      rd(`REG_STATUS, 32'h0000_0003, OK);
      wr(`REG_DELAY, 32'h0000_0004, OK);
      repeat (30) @(posedge aclk);
      check("lock after align reset", lock, 0);
      train(LOOP | 10'h0C0);
      check("lock at half rate", lock, 0);
      $display("Test phase align done");
      for (int w = 1; w < 3; w++) begin
         wr(`REG_CTRL, cw(LOOP | 10'h200, 4'(w)), OK);
         repeat (20) @(posedge aclk);
         check("alternate input", alternate_pad_input, w == 1);
      end
      $display("Test bypass done");
      for (logic [2:0] i = 0; i < 4; i++) begin
         wr(`REG_CTRL, cw({5'h00, i[0], i[1], i[0], 2'b10}, 4'h8), OK);
         repeat (3) @(posedge aclk);
         check("pins", {pad_oe, termination_on, input_buffer_on}, {i[0], i[1], i[0]});
      end
      $display("Test pins done");
      finish_test();
   end
endmodule
